// >>> gdr_pkg.sv
// Contract
// (R1) Die heat: 10-bit signed, left-aligned, low six don't-care
// (R2) Filtered self-test: 16-bit signed, low-pass filtered delta
// (R3) Filtered self-test outside limits sets self-test flag
// (R4) Raw self-test readable, never sets any flag
// (R5) Resonator error: 16-bit signed, low-pass filtered
// (R6) Low fault byte follows every data answer
// (R7) Flags set from chip conditions within 5 us
// (R8) Fault read or data command clears flags
// (R9) Still-present condition reasserts flag at once
// (R10) Silicon version word readable, 16 bits
// (R11) Host reads id at 0x0e then 0x10
// (R12) Read returns addressed byte high, next byte low
// (R13) Fault word bits 11..8 and 7..1 layout
`default_nettype none
package gdr_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DIE_HEAT_HIGH = 8'h02;
  localparam logic [7:0] ADDR_DIE_HEAT_LOW = 8'h03;
  localparam logic [7:0] ADDR_FILT_ST_HIGH = 8'h04;
  localparam logic [7:0] ADDR_FILT_ST_LOW = 8'h05;
  localparam logic [7:0] ADDR_RAW_ST_HIGH = 8'h06;
  localparam logic [7:0] ADDR_RAW_ST_LOW = 8'h07;
  localparam logic [7:0] ADDR_RES_ERR_HIGH = 8'h08;
  localparam logic [7:0] ADDR_RES_ERR_LOW = 8'h09;
  localparam logic [7:0] ADDR_FLAGS_HIGH = 8'h0a;
  localparam logic [7:0] ADDR_FLAGS_LOW = 8'h0b;
  localparam logic [7:0] ADDR_VERSION_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_VERSION_LOW = 8'h0d;
  localparam logic [7:0] ADDR_UID_BYTE3 = 8'h0e;
  localparam logic [7:0] ADDR_UID_BYTE2 = 8'h0f;
  localparam logic [7:0] ADDR_UID_BYTE1 = 8'h10;
  localparam logic [7:0] ADDR_UID_BYTE0 = 8'h11;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int DIE_HEAT_W = 10;
  localparam int DIE_HEAT_PAD_W = 6;
  localparam int WORD_W = 16;
  localparam int FLAG_W = 12;
  localparam int COND_W = 10;
  // Flag positions in the error flag word
  localparam int FLG_FAIL = 11;
  localparam int FLG_DRIVE_LEVEL = 10;
  localparam int FLG_SUPPLY_HIGH = 9;
  localparam int FLG_SUPPLY_LOW = 8;
  localparam int FLG_LOOP_LOCK = 7;
  localparam int FLG_RESONATOR = 6;
  localparam int FLG_STORED_DATA = 5;
  localparam int FLG_POWER_ON = 4;
  localparam int FLG_POWER_REG = 3;
  localparam int FLG_SELFTEST = 2;
  localparam int FLG_CHECK = 1;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 12'h000;

  // ----------------------------------------------------------------
  // Filters and limits
  // ----------------------------------------------------------------
  // Shift sets the corner relative to the sample tick rate
  localparam int SELFTEST_LP_SHIFT = 8;
  localparam int RESONATOR_LP_SHIFT = 2;
  localparam logic signed [15:0] SELFTEST_LIMIT_HIGH = 16'sh0640;
  localparam logic signed [15:0] SELFTEST_LIMIT_LOW = -16'sh0640;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int FLAG_SET_MAX_NS = 5000;
  // Longest allowed latency, rounded down; the path uses four cycles
  localparam int FLAG_SET_MAX_CYC = FLAG_SET_MAX_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Identity defaults (values arbitrary)
  // ----------------------------------------------------------------
  localparam logic [15:0] VERSION_DEFAULT = 16'h0a01;
  localparam logic [31:0] UNIQUE_ID_DEFAULT = 32'h1234_5678;

  typedef enum logic {GDR_KIND_READ, GDR_KIND_DATA_CMD} gdr_kind_e;
endpackage : gdr_pkg
`default_nettype wire

// >>> gdr_lowpass.sv
`timescale 1ns/1ps
`default_nettype none
module gdr_lowpass #(
  parameter int SHIFT = 4
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Synchronous reset, high
  input wire logic tick, // Sample strobe
  input wire logic signed [15:0] x, // New sample
  output logic signed [15:0] y // Filtered value
);
  localparam int ACC_W = 16 + SHIFT + 1;
  logic signed [ACC_W-1:0] acc_reg;
  logic signed [ACC_W-1:0] diff;

  // First-order IIR: cheap, no multiplier, corner set by shift
  always_comb begin
    diff = ($signed({{1{x[15]}}, x, {SHIFT{1'b0}}}) - acc_reg) >>> SHIFT;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_reg <= '0;
    end else if (tick) begin
      acc_reg <= acc_reg + diff;
    end
  end

  assign y = acc_reg[SHIFT+15:SHIFT];
endmodule : gdr_lowpass
`default_nettype wire

// >>> gdr_diag_regs.sv
`timescale 1ns/1ps
`default_nettype none
module gdr_diag_regs #(
  parameter logic [15:0] SILICON_VERSION = gdr_pkg::VERSION_DEFAULT, // Value arbitrary
  parameter logic [31:0] UNIQUE_ID = gdr_pkg::UNIQUE_ID_DEFAULT // Value arbitrary
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Synchronous reset, high
  input wire logic sample_tick, // Core sample strobe
  input wire logic signed [gdr_pkg::DIE_HEAT_W-1:0] die_heat_value, // Die temperature
  input wire logic signed [15:0] raw_selftest_value, // Raw self-test delta
  input wire logic signed [15:0] resonator_error_raw, // Unfiltered quadrature
  input wire logic [gdr_pkg::COND_W-1:0] fault_cond, // Async chip fault conditions
  output logic [gdr_pkg::FLAG_W-1:0] error_flag_word, // Latched flags, core view
  input wire logic link_clk, // Link side clock
  input wire logic link_rd_req, // Memory read request pulse
  input wire logic [7:0] link_rd_addr, // Read byte address
  input wire logic link_data_cmd, // Sensor data command pulse
  output logic link_busy, // Request outstanding
  output logic link_rd_valid, // Read answer pulse
  output logic [15:0] link_rd_data, // Read answer word
  output logic link_cmd_done, // Data command answer pulse
  output logic [7:0] error_flags_low_byte // Low fault byte of last answer
);
  import gdr_pkg::*;

  // ----------------------------------------------------------------
  // Core: sensor values
  // ----------------------------------------------------------------
  logic signed [15:0] filtered_selftest_value;
  logic signed [15:0] resonator_error_value;
  logic [15:0] die_heat_word;
  logic [15:0] raw_selftest_reg;

  // (R2) Filtered self-test delta
  gdr_lowpass #(
    .SHIFT(SELFTEST_LP_SHIFT)
  ) u_selftest_lp (
    .clk(clk),
    .rst(rst),
    .tick(sample_tick),
    .x(raw_selftest_value),
    .y(filtered_selftest_value)
  );

  // (R5) Filtered resonator error
  gdr_lowpass #(
    .SHIFT(RESONATOR_LP_SHIFT)
  ) u_resonator_lp (
    .clk(clk),
    .rst(rst),
    .tick(sample_tick),
    .x(resonator_error_raw),
    .y(resonator_error_value)
  );

  // (R1) Left-aligned temperature word
  always_ff @(posedge clk) begin
    if (rst) begin
      die_heat_word <= '0;
    end else if (sample_tick) begin
      die_heat_word <= {die_heat_value, {DIE_HEAT_PAD_W{1'b0}}};
    end
  end

  // (R4) Raw delta stored only
  always_ff @(posedge clk) begin
    if (rst) begin
      raw_selftest_reg <= '0;
    end else if (sample_tick) begin
      raw_selftest_reg <= raw_selftest_value;
    end
  end

  // ----------------------------------------------------------------
  // Core: fault conditions
  // ----------------------------------------------------------------
  logic [COND_W-1:0] cond_meta_reg;
  logic [COND_W-1:0] cond_sync_reg;
  logic selftest_out_of_range;
  logic [FLAG_W-1:0] cond_now;

  // (R7) Two-flop capture of chip conditions
  always_ff @(posedge clk) begin
    if (rst) begin
      cond_meta_reg <= '0;
      cond_sync_reg <= '0;
    end else begin
      cond_meta_reg <= fault_cond;
      cond_sync_reg <= cond_meta_reg;
    end
  end

  // (R3) Filtered value against limits
  always_comb begin
    selftest_out_of_range = (filtered_selftest_value > SELFTEST_LIMIT_HIGH) ||
                            (filtered_selftest_value < SELFTEST_LIMIT_LOW);
  end

  // (R13) Condition vector in word order
  always_comb begin
    cond_now = '0;
    cond_now[FLG_FAIL:FLG_SUPPLY_LOW] = cond_sync_reg[COND_W-1:COND_W-4];
    cond_now[FLG_LOOP_LOCK:FLG_POWER_REG] = cond_sync_reg[5:1];
    cond_now[FLG_SELFTEST] = selftest_out_of_range;
    cond_now[FLG_CHECK] = cond_sync_reg[0];
  end

  // ----------------------------------------------------------------
  // Core: request crossing
  // ----------------------------------------------------------------
  logic req_tgl_reg;
  logic req_meta_reg;
  logic req_sync_reg;
  logic req_seen_reg;
  logic [7:0] link_addr_reg;
  gdr_kind_e link_kind_reg;
  logic req_event;
  logic clear_flags;
  logic [FLAG_W-1:0] flags_reg;
  logic [15:0] ans_data_reg;
  logic [7:0] ans_low_reg;
  logic ans_tgl_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
      req_seen_reg <= 1'b0;
    end else begin
      req_meta_reg <= req_tgl_reg;
      req_sync_reg <= req_meta_reg;
      req_seen_reg <= req_sync_reg;
    end
  end

  // Address and kind stay still on the link side until answered
  always_comb begin
    req_event = req_sync_reg ^ req_seen_reg;
  end

  // (R8) Fault read or data command clears
  always_comb begin
    clear_flags = req_event && ((link_kind_reg == GDR_KIND_DATA_CMD) ||
                  (link_addr_reg == ADDR_FLAGS_HIGH) || (link_addr_reg == ADDR_FLAGS_LOW));
  end

  // (R9) Live condition wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_reg <= FLAGS_RESET;
    end else if (clear_flags) begin
      flags_reg <= cond_now;
    end else begin
      flags_reg <= flags_reg | cond_now;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      error_flag_word <= FLAGS_RESET;
    end else begin
      error_flag_word <= flags_reg;
    end
  end

  // ----------------------------------------------------------------
  // Core: byte map
  // ----------------------------------------------------------------
  function automatic logic [7:0] byte_at(input logic [7:0] a, input logic [15:0] heat,
                                         input logic [15:0] filt, input logic [15:0] raw,
                                         input logic [15:0] res, input logic [15:0] flg);
    logic [7:0] b;
    b = 8'h00;
    if (a == ADDR_DIE_HEAT_HIGH) begin
      b = heat[15:8];
    end else if (a == ADDR_DIE_HEAT_LOW) begin
      b = heat[7:0];
    end else if (a == ADDR_FILT_ST_HIGH) begin
      b = filt[15:8];
    end else if (a == ADDR_FILT_ST_LOW) begin
      b = filt[7:0];
    end else if (a == ADDR_RAW_ST_HIGH) begin
      b = raw[15:8];
    end else if (a == ADDR_RAW_ST_LOW) begin
      b = raw[7:0];
    end else if (a == ADDR_RES_ERR_HIGH) begin
      b = res[15:8];
    end else if (a == ADDR_RES_ERR_LOW) begin
      b = res[7:0];
    end else if (a == ADDR_FLAGS_HIGH) begin
      b = flg[15:8];
    end else if (a == ADDR_FLAGS_LOW) begin
      b = flg[7:0];
    end else if (a == ADDR_VERSION_HIGH) begin
      // (R10) Version word
      b = SILICON_VERSION[15:8];
    end else if (a == ADDR_VERSION_LOW) begin
      b = SILICON_VERSION[7:0];
    end else if (a == ADDR_UID_BYTE3) begin
      // (R11) Id upper half first
      b = UNIQUE_ID[31:24];
    end else if (a == ADDR_UID_BYTE2) begin
      b = UNIQUE_ID[23:16];
    end else if (a == ADDR_UID_BYTE1) begin
      b = UNIQUE_ID[15:8];
    end else if (a == ADDR_UID_BYTE0) begin
      b = UNIQUE_ID[7:0];
    end
    return b;
  endfunction : byte_at

  logic [15:0] flag_word16;
  logic [15:0] read_word;
  logic [7:0] next_addr;

  always_comb begin
    flag_word16 = {{(WORD_W-FLAG_W){1'b0}}, flags_reg};
    next_addr = link_addr_reg + 8'h01;
    // (R12) Addressed byte high, next byte low
    read_word = {byte_at(link_addr_reg, die_heat_word, filtered_selftest_value, raw_selftest_reg,
                         resonator_error_value, flag_word16),
                 byte_at(next_addr, die_heat_word, filtered_selftest_value, raw_selftest_reg,
                         resonator_error_value, flag_word16)};
  end

  // Answer words are taken before the clear lands, so the host sees the set flags
  always_ff @(posedge clk) begin
    if (rst) begin
      ans_data_reg <= '0;
      ans_low_reg <= '0;
      ans_tgl_reg <= 1'b0;
    end else if (req_event) begin
      ans_data_reg <= read_word;
      // (R6) Low byte with every answer
      ans_low_reg <= flag_word16[7:0];
      ans_tgl_reg <= ~ans_tgl_reg;
    end
  end

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  typedef enum logic {GDR_LK_IDLE, GDR_LK_WAIT} gdr_link_state_e;
  gdr_link_state_e lk_state_reg;
  logic lrst_meta_reg;
  logic lrst_reg;
  logic ack_meta_reg;
  logic ack_sync_reg;
  logic ack_seen_reg;
  logic ack_event;

  // Reset reaches the link domain through two flops
  always_ff @(posedge link_clk) begin
    lrst_meta_reg <= rst;
    lrst_reg <= lrst_meta_reg;
  end

  always_ff @(posedge link_clk) begin
    if (lrst_reg) begin
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
    end else begin
      ack_meta_reg <= ans_tgl_reg;
      ack_sync_reg <= ack_meta_reg;
      ack_seen_reg <= ack_sync_reg;
    end
  end

  always_comb begin
    ack_event = ack_sync_reg ^ ack_seen_reg;
  end

  // Requests while busy are dropped; the link must wait for the answer
  always_ff @(posedge link_clk) begin
    if (lrst_reg) begin
      lk_state_reg <= GDR_LK_IDLE;
      req_tgl_reg <= 1'b0;
      link_addr_reg <= '0;
      link_kind_reg <= GDR_KIND_READ;
    end else begin
      case (lk_state_reg)
        GDR_LK_IDLE: begin
          if (link_data_cmd) begin
            link_kind_reg <= GDR_KIND_DATA_CMD;
            req_tgl_reg <= ~req_tgl_reg;
            lk_state_reg <= GDR_LK_WAIT;
          end else if (link_rd_req) begin
            link_kind_reg <= GDR_KIND_READ;
            link_addr_reg <= link_rd_addr;
            req_tgl_reg <= ~req_tgl_reg;
            lk_state_reg <= GDR_LK_WAIT;
          end
        end
        GDR_LK_WAIT: begin
          if (ack_event) begin
            lk_state_reg <= GDR_LK_IDLE;
          end
        end
        default: begin
          lk_state_reg <= GDR_LK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst_reg) begin
      link_busy <= 1'b0;
    end else if (lk_state_reg == GDR_LK_IDLE) begin
      link_busy <= link_data_cmd || link_rd_req;
    end else begin
      link_busy <= !ack_event;
    end
  end

  // Core answer registers are stable once the ack toggle is seen
  always_ff @(posedge link_clk) begin
    if (lrst_reg) begin
      link_rd_valid <= 1'b0;
      link_cmd_done <= 1'b0;
      link_rd_data <= '0;
      error_flags_low_byte <= '0;
    end else begin
      link_rd_valid <= 1'b0;
      link_cmd_done <= 1'b0;
      if ((lk_state_reg == GDR_LK_WAIT) && ack_event) begin
        // (R6) Low byte follows data answer
        error_flags_low_byte <= ans_low_reg;
        if (link_kind_reg == GDR_KIND_READ) begin
          link_rd_data <= ans_data_reg;
          link_rd_valid <= 1'b1;
        end else begin
          link_cmd_done <= 1'b1;
        end
      end
    end
  end
endmodule : gdr_diag_regs
`default_nettype wire

// >>> gdr_diag_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module gdr_diag_regs_monitor
  import gdr_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst, // Reset, high
  input wire logic [gdr_pkg::COND_W-1:0] fault_cond, // Conditions
  input wire logic [gdr_pkg::FLAG_W-1:0] error_flag_word, // Flags
  input wire logic link_clk, // Link clock
  input wire logic link_rd_req, // Read request
  input wire logic [7:0] link_rd_addr, // Read address
  input wire logic link_data_cmd, // Data command
  input wire logic link_busy, // Busy
  input wire logic link_rd_valid, // Read answer
  input wire logic [15:0] link_rd_data, // Read word
  input wire logic link_cmd_done, // Command answer
  input wire logic [7:0] error_flags_low_byte // Low fault byte
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  logic [7:0] addr_reg;
  always_ff @(posedge link_clk) begin
    if (rst) begin
      addr_reg <= 8'hff;
    end else if (link_rd_req && !link_data_cmd && !link_busy) begin
      addr_reg <= link_rd_addr;
    end
  end
  property p_valid_pulse;
    @(posedge link_clk) disable iff (rst) link_rd_valid |=> !link_rd_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("read answer too long");
  property p_done_pulse;
    @(posedge link_clk) disable iff (rst) link_cmd_done |=> !link_cmd_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("command answer too long");
  property p_busy_ends;
    @(posedge link_clk) disable iff (rst) $rose(link_busy) |-> ##[1:12] (link_rd_valid || link_cmd_done);
  endproperty
  a_busy_ends: assert property (p_busy_ends) else $error("request never answered");
  property p_answer_free;
    @(posedge link_clk) disable iff (rst) (link_rd_valid || link_cmd_done) |-> !link_busy;
  endproperty
  a_answer_free: assert property (p_answer_free) else $error("busy during answer");
  property p_data_hold;
    @(posedge link_clk) disable iff (rst) $changed(link_rd_data) |-> link_rd_valid;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("read word changed alone");
  property p_flag_map;
    @(posedge link_clk) disable iff (rst)
      (link_rd_valid && addr_reg == 8'h0a) |-> (link_rd_data[15:12] == 4'h0 && link_rd_data[0] == 1'b0);
  endproperty
  a_flag_map: assert property (p_flag_map) else $error("flag word unused bits set");
  property p_low_byte;
    @(posedge link_clk) disable iff (rst)
      (link_rd_valid && addr_reg == 8'h0a) |-> ##[0:1] (error_flags_low_byte == link_rd_data[7:0]);
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low fault byte differs");
  property p_unmapped;
    @(posedge link_clk) disable iff (rst) (link_rd_valid && addr_reg == 8'h00) |-> link_rd_data == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_flag_set;
    @(posedge clk) disable iff (rst) $rose(fault_cond[9]) |-> ##[1:4] error_flag_word[11];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("fail flag late");
  property p_flag_cause;
    @(posedge clk) disable iff (rst)
      $rose(error_flag_word[11]) |-> ($past(fault_cond[9], 3) || $past(fault_cond[9], 4));
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("fail flag without cause");
  c_read: cover property (@(posedge link_clk) link_rd_valid);
  c_cmd: cover property (@(posedge link_clk) link_cmd_done);
  c_flag: cover property (@(posedge clk) $rose(error_flag_word[2]));
endmodule : gdr_diag_regs_monitor
bind gdr_diag_regs gdr_diag_regs_monitor mon (.clk(clk), .rst(rst), .fault_cond(fault_cond),
  .error_flag_word(error_flag_word), .link_clk(link_clk), .link_rd_req(link_rd_req),
  .link_rd_addr(link_rd_addr), .link_data_cmd(link_data_cmd), .link_busy(link_busy),
  .link_rd_valid(link_rd_valid), .link_rd_data(link_rd_data), .link_cmd_done(link_cmd_done),
  .error_flags_low_byte(error_flags_low_byte));
`default_nettype wire

// >>> gdr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module gdr_host_model (
  input wire logic link_clk, // Link clock
  output logic link_rd_req, // Read request
  output logic [7:0] link_rd_addr, // Read address
  output logic link_data_cmd, // Data command
  input wire logic link_rd_valid, // Read answer
  input wire logic [15:0] link_rd_data, // Read word
  input wire logic link_cmd_done // Command answer
);
  // ----------------------------------------------------------------
  // Requests, one outstanding, answer awaited under a bound
  // ----------------------------------------------------------------
  initial begin
    link_rd_req = 1'b0;
    link_rd_addr = 8'h5a;
    link_data_cmd = 1'b0;
  end
  // even address, word taken once the answer stands
  task automatic do_read(input logic [7:0] addr, output logic [15:0] data);
    data = 'x;
    @(posedge link_clk);
    #1;
    link_rd_req = 1'b1;
    link_rd_addr = addr;
    @(posedge link_clk);
    #1;
    link_rd_req = 1'b0;
    // Released address shows garbage, never the last value
    link_rd_addr = ~addr;
    for (int n = 0; n < 40; n++) begin
      @(posedge link_clk);
      #1;
      if (link_rd_valid === 1'b1) begin
        data = link_rd_data;
        break;
      end
    end
  endtask : do_read
  task automatic do_cmd(output logic ok);
    ok = 1'b0;
    @(posedge link_clk);
    #1;
    link_data_cmd = 1'b1;
    @(posedge link_clk);
    #1;
    link_data_cmd = 1'b0;
    for (int n = 0; n < 40; n++) begin
      @(posedge link_clk);
      #1;
      if (link_cmd_done === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
  endtask : do_cmd
endmodule : gdr_host_model
`default_nettype wire

// >>> gyro_diagnostic_register_set_bench.sv
`timescale 1ns/1ps
`default_nettype none
module gyro_diagnostic_register_set_bench;
  import gdr_pkg::*;
  typedef struct packed {logic [7:0] addr; logic [15:0] exp;} gdr_row_s;
  // ----------------------------------------------------------------
  // Stimulus and checks
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic sample_tick = 1'b0;
  logic signed [DIE_HEAT_W-1:0] die_heat = 10'h0c8;
  logic signed [15:0] raw_st = 16'sh0100;
  logic signed [15:0] res_raw = 16'sh0000;
  logic [COND_W-1:0] fault_cond = '0;
  logic [FLAG_W-1:0] flags;
  logic rd_req, data_cmd, busy, rd_valid, cmd_done;
  logic [7:0] rd_addr, low_byte;
  logic [15:0] rd_data;
  int mismatches = 0;
  int checked = 0;
  gdr_row_s rows [9] = '{'{8'h02, 16'h3200}, '{8'h06, 16'h0100}, '{8'h08, 16'h0000},
    '{8'h0a, 16'h0000}, '{8'h0c, VERSION_DEFAULT}, '{8'h0e, UNIQUE_ID_DEFAULT[31:16]},
    '{8'h10, UNIQUE_ID_DEFAULT[15:0]}, '{8'h00, 16'h0000}, '{8'h12, 16'h0000}};
  always #10 clk = ~clk;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  gdr_diag_regs dut (.clk(clk), .rst(rst), .sample_tick(sample_tick), .die_heat_value(die_heat),
    .raw_selftest_value(raw_st), .resonator_error_raw(res_raw), .fault_cond(fault_cond),
    .error_flag_word(flags), .link_clk(link_clk), .link_rd_req(rd_req), .link_rd_addr(rd_addr),
    .link_data_cmd(data_cmd), .link_busy(busy), .link_rd_valid(rd_valid), .link_rd_data(rd_data),
    .link_cmd_done(cmd_done), .error_flags_low_byte(low_byte));
  gdr_host_model host (.link_clk(link_clk), .link_rd_req(rd_req), .link_rd_addr(rd_addr),
    .link_data_cmd(data_cmd), .link_rd_valid(rd_valid), .link_rd_data(rd_data), .link_cmd_done(cmd_done));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic finish_test();
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  function automatic int fpos(input int k);
    return (k >= 2) ? k + 2 : ((k == 1) ? 3 : 1);
  endfunction : fpos
  initial begin
    #500us;
    mismatches++;
    finish_test();
  end
  initial begin
    logic [15:0] d;
    logic ok;
    // Held past five cycles so the link side sees enough of its own edges
    step(10);
    rst = 1'b0;
    repeat (6) @(posedge link_clk);
    step(1);
    sample_tick = 1'b1;
    step(1);
    sample_tick = 1'b0;
    step(2);
    for (int i = 0; i < 9; i++) begin
      host.do_read(rows[i].addr, d);
      chk(d, rows[i].exp);
    end
    for (int k = 0; k < COND_W; k++) begin
      step(1);
      fault_cond = 10'h001 << k;
      step(2);
      fault_cond = '0;
      step(5);
      chk({4'h0, flags}, 16'h0001 << fpos(k));
      host.do_read(8'h0a, d);
      chk(d, 16'h0001 << fpos(k));
      chk({8'h00, low_byte}, 16'h00ff & (16'h0001 << fpos(k)));
      host.do_read(8'h0a, d);
      chk(d, 16'h0000);
    end
    step(1);
    fault_cond = 10'h200;
    for (int i = 0; i < 2; i++) begin
      host.do_read(8'h0a, d);
      chk(d, 16'h0800);
    end
    fault_cond = 10'h001;
    step(2);
    fault_cond = '0;
    host.do_cmd(ok);
    chk({15'h0000, ok}, 16'h0001);
    chk({8'h00, low_byte}, 16'h0002);
    host.do_read(8'h0a, d);
    chk(d, 16'h0000);
    step(1);
    raw_st = 16'sh7fff;
    res_raw = 16'sh0100;
    sample_tick = 1'b1;
    step(1);
    sample_tick = 1'b0;
    step(6);
    chk({15'h0000, flags[FLG_SELFTEST]}, 16'h0000);
    host.do_read(8'h06, d);
    chk(d, 16'h7fff);
    step(1);
    sample_tick = 1'b1;
    step(2000);
    sample_tick = 1'b0;
    host.do_read(8'h04, d);
    chk({15'h0000, $signed(d) > SELFTEST_LIMIT_HIGH}, 16'h0001);
    // Settled filter may sit one count below its input
    host.do_read(8'h08, d);
    chk({15'h0000, (d == 16'h00ff) || (d == 16'h0100)}, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      host.do_read(8'h0a, d);
      chk(d, 16'h0004);
    end
    // Mid-run reset must drop latched flags, filters and link answers
    fault_cond = 10'h100;
    step(8);
    chk({4'h0, flags}, 16'h0404);
    rst = 1'b1;
    fault_cond = '0;
    step(10);
    chk({4'h0, flags}, 16'h0000);
    chk({8'h00, low_byte}, 16'h0000);
    chk(rd_data, 16'h0000);
    rst = 1'b0;
    repeat (6) @(posedge link_clk);
    step(1);
    host.do_read(8'h0a, d);
    chk(d, 16'h0000);
    host.do_read(8'h04, d);
    chk(d, 16'h0000);
    finish_test();
  end
endmodule : gyro_diagnostic_register_set_bench
`default_nettype wire
